// ### dv/adcp_ctrl_props.sv
// Checker for the converter control block, bound to its top module.
// Assumes pins are driven asynchronously and synchronised inside the block.
`default_nettype none
`include "adcp_consts.svh"
module adcp_ctrl_props
  import adcp_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCP_CONV_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic device_select_n,
  input wire logic read_convert_n,
  input wire adcp_bus_t result_bus,
  input wire logic busy,
  input wire logic sample_hold,
  input wire logic cmd_ignored
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] low_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= busy ? 8'h00 : low_cnt + 8'h01;
    end
  end
  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_hiz_conv: assert property (!busy |-> !result_bus.oe)
    else $error("bus driven during conversion");
  chk_hiz_desel: assert property (device_select_n [*4] |-> !result_bus.oe)
    else $error("bus driven while deselected");
  chk_hiz_convline: assert property (!read_convert_n [*4] |-> !result_bus.oe)
    else $error("bus driven while convert line low");
  chk_read_enable: assert property (
    (!device_select_n && read_convert_n && busy) [*4] |-> result_bus.oe)
    else $error("bus not enabled in read mode");
  chk_start_busy: assert property (
    $fell(read_convert_n || device_select_n) && busy
    ##1 !(read_convert_n || device_select_n) |-> ##[1:4] !busy)
    else $error("start not followed by busy low");
  chk_hold_busy: assert property (sample_hold == !busy)
    else $error("hold and busy disagree");
  chk_conv_len: assert property ($rose(busy) |-> low_cnt >= CONV_CYCLES + 1)
    else $error("conversion too short");
  chk_data_latch: assert property ($changed(result_bus.data) |-> $rose(busy))
    else $error("result changed outside busy rise");
  chk_ignore_busy: assert property (cmd_ignored |-> !$past(busy))
    else $error("ignore flag outside conversion");
  chk_ignore_pulse: assert property (cmd_ignored |=> !cmd_ignored)
    else $error("ignore flag longer than one cycle");
  cov_done: cover property ($rose(busy));
  cov_ignored: cover property (cmd_ignored);
  cov_read: cover property ($rose(result_bus.oe));
endmodule : adcp_ctrl_props
bind adcp_ctrl adcp_ctrl_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .clk(clk), .reset_n(reset_n), .device_select_n(device_select_n),
  .read_convert_n(read_convert_n), .result_bus(result_bus), .busy(busy),
  .sample_hold(sample_hold), .cmd_ignored(cmd_ignored)
);
`default_nettype wire

// ### dv/adcp_ctrl_tb_top.sv
// Self-checking bench for the converter control block with a host model.
// Assumes the core stream feeds offset-binary words through the block's FIFO.
`default_nettype none
module adcp_ctrl_tb_top
  import adcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n, device_select_n, read_convert_n, sample_valid, sample_ready;
  logic busy, sample_hold, cmd_ignored, acq_done;
  logic [11:0] sample_data, captured;
  logic ign_seen = 1'b0;
  adcp_bus_t result_bus;
  int fail_count = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (cmd_ignored === 1'b1) ign_seen <= 1'b1;
  adcp_ctrl #(.CONV_CYCLES(8)) DUT (
    .clk(clk), .reset_n(reset_n), .device_select_n(device_select_n),
    .read_convert_n(read_convert_n), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .result_bus(result_bus),
    .busy(busy), .sample_hold(sample_hold), .cmd_ignored(cmd_ignored), .acq_done(acq_done)
  );
  adcp_host_model u_host (
    .clk(clk), .reset_n(reset_n), .busy(busy), .result_bus(result_bus), .captured(captured)
  );
  // ========================================================================
  // Shared tasks
  task automatic results;
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step
  // Valid stays high from one word to the next, so it never toggles twice in
  // one time step; the caller drops it after the last word.
  task automatic push(input logic [11:0] w);
    sample_data = w;
    sample_valid = 1'b1;
    while (sample_ready !== 1'b1) step(1);
    step(1);
  endtask : push
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 100 && busy !== lvl; i++) step(1);
    chk("busy", {11'h000, busy}, {11'h000, lvl});
  endtask : wait_busy
  task automatic conv_rc(input logic [11:0] exp);
    read_convert_n = 1'b0;
    step(2);
    read_convert_n = 1'b1;
    wait_busy(1'b0);
    chk("oe_conv", {11'h000, result_bus.oe}, 12'h000);
    chk("hold_conv", {11'h000, sample_hold}, 12'h001);
    wait_busy(1'b1);
    chk("hold_done", {11'h000, sample_hold}, 12'h000);
    chk("acq_start", {11'h000, acq_done}, 12'h000);
    step(3);
    chk("acq_done", {11'h000, acq_done}, 12'h001);
    chk("captured", captured, exp);
    chk("oe_read", {11'h000, result_bus.oe}, 12'h001);
    chk("data", result_bus.data, exp);
  endtask : conv_rc
  // ========================================================================
  // Scenarios
  task automatic t_rc_mode;
    device_select_n = 1'b0;
    push(12'h0A5);
    sample_valid = 1'b0;
    conv_rc(12'h8A5);
    device_select_n = 1'b1;
    step(4);
    chk("oe_desel", {11'h000, result_bus.oe}, 12'h000);
  endtask : t_rc_mode
  task automatic t_cs_start;
    read_convert_n = 1'b0;
    push(12'hF00);
    push(12'h7FF);
    sample_valid = 1'b0;
    device_select_n = 1'b0;
    wait_busy(1'b0);
    read_convert_n = 1'b1;
    step(3);
    read_convert_n = 1'b0;
    wait_busy(1'b1);
    step(3);
    chk("ignored", {11'h000, ign_seen}, 12'h001);
    chk("oe_rc_low", {11'h000, result_bus.oe}, 12'h000);
    device_select_n = 1'b1;
    read_convert_n = 1'b1;
    step(4);
    device_select_n = 1'b0;
    step(4);
    chk("oe_cs", {11'h000, result_bus.oe}, 12'h001);
    chk("data_cs", result_bus.data, 12'h700);
  endtask : t_cs_start
  task automatic t_fifo_full;
    int i;
    for (i = 1; i < 16; i++) push({i[3:0], 8'hC3});
    sample_valid = 1'b0;
    step(2);
    chk("ready_full", {11'h000, sample_ready}, 12'h000);
    conv_rc(12'hFFF);
    for (i = 1; i < 16; i++) conv_rc({i[3:0], 8'hC3} ^ 12'h800);
    chk("ready_empty", {11'h000, sample_ready}, 12'h001);
  endtask : t_fifo_full
  initial begin
    reset_n = 1'b0;
    device_select_n = 1'b1;
    read_convert_n = 1'b1;
    sample_valid = 1'b0;
    sample_data = 12'h000;
    repeat (5) @(posedge clk);
    #10;
    reset_n = 1'b1;
    step(1);
    t_rc_mode;
    t_cs_start;
    t_fifo_full;
    results;
  end
  initial begin
    #1000000;
    fail_count++;
    results;
  end
endmodule : adcp_ctrl_tb_top
`default_nettype wire

// ### dv/adcp_host_model.sv
// Host side model: latches the result bus on the rising edge of busy.
// Assumes the bench drives the select and read/convert lines itself.
`default_nettype none
`include "adcp_consts.svh"
module adcp_host_model
  import adcp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic busy,
  input wire adcp_bus_t result_bus,
  output logic [`ADCP_RES_W-1:0] captured
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy_prev;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_prev <= 1'b1;
      captured <= `ADCP_RESULT_RST;
    end else begin
      busy_prev <= busy;
      // An undriven bus reads as the inverse of the last word, never as a lucky match.
      if (busy && !busy_prev) begin
        captured <= result_bus.oe ? result_bus.data : ~captured;
      end
    end
  end
endmodule : adcp_host_model
`default_nettype wire

// ### rtl/adcp_consts.svh
// Constants for the parallel converter interface: widths, depths, timing counts.
// Assumes a 100 ns system clock; every count derives from a time in nanoseconds.
`ifndef ADCP_CONSTS_SVH
`define ADCP_CONSTS_SVH

// ==========================================================================
// Widths and depths
`define ADCP_RES_W 12
`define ADCP_MSB 11
`define ADCP_LSB 0
`define ADCP_FIFO_DEPTH 16
`define ADCP_CNT_W 8

// ==========================================================================
// Reset values
`define ADCP_RESULT_RST 12'h000
`define ADCP_PIN_IDLE 1'b1

// ==========================================================================
// Timing
`define ADCP_CLK_NS 100
`define ADCP_CONV_NS 910
`define ADCP_CONV_CYC ((`ADCP_CONV_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS)
`define ADCP_ACQ_NS 200
`define ADCP_ACQ_CYC ((`ADCP_ACQ_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS)
`define ADCP_CONV_PULSE_NS 40

`endif

// ### rtl/adcp_ctrl.sv
// Control and parallel read-out of a 12-bit sampling converter, device side.
// Assumes the host drives device_select_n and read_convert_n asynchronously,
// and that the converter core delivers offset-binary codes as a stream.
//
// Functional notes
// - The result bus is not driven while select is high, read/convert is low or busy is low.
// - Each result is a 12-bit word on the result bus with bit 11 the MSB and bit 0 the LSB.
// - With select low, a falling read/convert enters hold and starts a conversion.
// - With select low and no conversion running, a rising read/convert enables the bus.
// - With read/convert low, a falling select starts a conversion just the same.
// - With read/convert high and idle, a falling select enables the bus with the stored result.
// - Busy falls at conversion start and rises only once the new result is latched.
// - With select low and read/convert high, valid data is on the bus when busy rises.
// - Convert commands arriving while busy is low are ignored.
// - Results are coded in binary two's complement.
// - Select and read/convert combine as a level OR, so either may go low last.
`default_nettype none

`include "adcp_consts.svh"

module adcp_ctrl
  import adcp_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCP_CONV_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic device_select_n,
  input wire logic read_convert_n,
  input wire logic [`ADCP_RES_W-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  output adcp_bus_t result_bus,
  output logic busy,
  output logic sample_hold,
  output logic cmd_ignored,
  output logic acq_done
);

  localparam int CW = `ADCP_CNT_W;
  localparam int ACQ_CYCLES = `ADCP_ACQ_CYC;

  // ========================================================================
  // Code conversion
  // The core produces offset binary; flipping the sign bit gives two's
  // complement without any adder in the path.
  function automatic logic [`ADCP_RES_W-1:0] to_twos(
    input logic [`ADCP_RES_W-1:0] code
  );
    logic [`ADCP_RES_W-1:0] res;
    res = code;
    res[`ADCP_MSB] = ~code[`ADCP_MSB];
    return res;
  endfunction : to_twos

  // ========================================================================
  // Sample buffer
  // Samples from the core wait here until a conversion finishes; when no
  // conversion is requested the buffer fills and stalls the core.
  logic fifo_valid;
  logic fifo_pop;
  logic [`ADCP_RES_W-1:0] fifo_data;

  adcp_fifo #(
    .WIDTH(`ADCP_RES_W),
    .DEPTH(`ADCP_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(sample_valid),
    .in_data(sample_data),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ========================================================================
  // State
  adcp_state_t st;
  adcp_state_t next_st;
  logic start_lvl;
  logic start_edge;
  logic read_lvl;

  always_comb begin
    next_st = st;
    fifo_pop = 1'b0;

    // Both control pins are asynchronous to clk and pass two flops first.
    next_st.cs_meta = device_select_n;
    next_st.cs_sync = st.cs_meta;
    next_st.rc_meta = read_convert_n;
    next_st.rc_sync = st.rc_meta;

    // Active-low OR: a start needs both lines low, whichever fell last.
    start_lvl = ~st.cs_sync & ~st.rc_sync;
    start_edge = start_lvl & ~st.start_prev;
    next_st.start_prev = start_lvl;
    read_lvl = ~st.cs_sync & st.rc_sync;

    next_st.cmd_ignored = 1'b0;

    case (st.phase)
      ADCP_IDLE: begin
        if (start_edge) begin
          next_st.phase = ADCP_CONV;
          next_st.cnt = CW'(CONV_CYCLES - 1);
          next_st.busy = 1'b0;
          next_st.hold = 1'b1;
        end else if (st.acq_cnt != '0) begin
          next_st.acq_cnt = st.acq_cnt - 1'b1;
        end
      end
      ADCP_CONV: begin
        if (start_edge) begin
          next_st.cmd_ignored = 1'b1;
        end
        if (st.cnt == '0) begin
          next_st.phase = ADCP_LATCH;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      ADCP_LATCH: begin
        if (start_edge) begin
          next_st.cmd_ignored = 1'b1;
        end
        // The conversion cannot end before the core has a sample; busy
        // stays low while the buffer is empty.
        if (fifo_valid) begin
          fifo_pop = 1'b1;
          next_st.result = to_twos(fifo_data);
          next_st.busy = 1'b1;
          next_st.hold = 1'b0;
          next_st.phase = ADCP_IDLE;
          next_st.acq_cnt = CW'(ACQ_CYCLES);
        end
      end
      default: begin
        next_st.phase = ADCP_IDLE;
        next_st.busy = 1'b1;
        next_st.hold = 1'b0;
      end
    endcase

    next_st.acq_done = (next_st.acq_cnt == '0);

    // Drivers follow the level of the lines, which covers both the
    // read/convert rising and the select falling enables, and switch on in
    // the same edge that raises busy so the data is valid with it.
    next_st.bus.oe = read_lvl & (next_st.phase == ADCP_IDLE);
    next_st.bus.data = next_st.result;
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.cs_meta <= `ADCP_PIN_IDLE;
      st.cs_sync <= `ADCP_PIN_IDLE;
      st.rc_meta <= `ADCP_PIN_IDLE;
      st.rc_sync <= `ADCP_PIN_IDLE;
      st.phase <= ADCP_IDLE;
      st.result <= `ADCP_RESULT_RST;
      st.busy <= 1'b1;
      st.acq_done <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs, all straight from the state register
  assign result_bus = st.bus;
  assign busy = st.busy;
  assign sample_hold = st.hold;
  assign cmd_ignored = st.cmd_ignored;
  assign acq_done = st.acq_done;

endmodule : adcp_ctrl

`default_nettype wire

// ### rtl/adcp_fifo.sv
// Synchronous FIFO with valid/ready on both sides, parameterised width and depth.
// Assumes one clock; DEPTH is a power of two so the pointers wrap naturally.
`default_nettype none

`include "adcp_consts.svh"

module adcp_fifo #(
  parameter int WIDTH = `ADCP_RES_W,
  parameter int DEPTH = `ADCP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic ready;
  } adcp_fifo_state_t;

  adcp_fifo_state_t st;
  adcp_fifo_state_t next_st;
  logic push;
  logic pop;

  // ========================================================================
  // Next state
  always_comb begin
    next_st = st;
    push = in_valid & st.ready;
    pop = out_ready & (st.count != '0);
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10: next_st.count = st.count + 1'b1;
      2'b01: next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
    // Ready is registered so the source sees a clean flop, at the cost of
    // no push into a full FIFO in the same cycle as a pop.
    next_st.ready = (next_st.count != CW'(DEPTH));
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.ready;
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd_ptr];

endmodule : adcp_fifo

`default_nettype wire

// ### rtl/adcp_pkg.sv
// Types shared by the converter interface: phase encoding, result bus carrier, state.
// Assumes adcp_consts.svh is on the include path.
`default_nettype none

`include "adcp_consts.svh"

package adcp_pkg;

  // ========================================================================
  // Conversion phase, Gray coded along idle, convert, latch.
  typedef enum logic [1:0] {
    ADCP_IDLE = 2'b00,
    ADCP_CONV = 2'b01,
    ADCP_LATCH = 2'b11
  } adcp_phase_t;

  // ========================================================================
  // Three-state result bus: data word and its output enable.
  typedef struct packed {
    logic oe;
    logic [`ADCP_RES_W-1:0] data;
  } adcp_bus_t;

  // ========================================================================
  // Whole state of the control block except the sample FIFO, which keeps its own.
  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic rc_meta;
    logic rc_sync;
    logic start_prev;
    adcp_phase_t phase;
    logic [`ADCP_CNT_W-1:0] cnt;
    logic [`ADCP_CNT_W-1:0] acq_cnt;
    logic [`ADCP_RES_W-1:0] result;
    adcp_bus_t bus;
    logic busy;
    logic hold;
    logic cmd_ignored;
    logic acq_done;
  } adcp_state_t;

endpackage : adcp_pkg

`default_nettype wire
